/* File: design/lom_gain_step.sv */
// Gain stepper: walks an applied gain code one step per enable.
// Assumes step_en is a one-cycle pulse from a shared divider.
module lom_gain_step
   import lom_pkg::*;
#(
   parameter int W = VOL_W
) (
   input  wire logic         clock,
   input  wire logic         rst,
   input  wire logic         step_en,
   input  wire logic [W-1:0] target,
   output logic      [W-1:0] applied,
   output logic              busy
);
   // One code per step keeps the analog gain free of zipper jumps
   function automatic logic [W-1:0] toward(input logic [W-1:0] cur,
                                           input logic [W-1:0] tgt);
      if (cur < tgt) begin
         return W'(cur + 1'b1);
      end else if (cur > tgt) begin
         return W'(cur - 1'b1);
      end
      return cur;
   endfunction : toward

   logic [W-1:0] next_applied;

   always_comb begin
      next_applied = toward(applied, target);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         applied <= '0;
      end else if (step_en) begin
         applied <= next_applied;
      end
   end

   assign busy = (applied != target);
endmodule : lom_gain_step

/* File: design/lom_regs.sv */
// Line output mixer control registers and gain stepping.
// Assumes the control bus front end presents one byte access per cycle.
module lom_regs
   import lom_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              rst,
   input  wire logic [ADDR_W-1:0] reg_addr,
   input  wire logic [DATA_W-1:0] reg_wdata,
   input  wire logic              reg_write,
   input  wire logic              reg_read,
   output logic      [DATA_W-1:0] reg_rdata,
   output logic                   reg_rvalid,
   output logic                   ramp_left_route,
   output logic      [VOL_W-1:0]  ramp_left_vol,
   output logic                   rconv_left_route,
   output logic      [VOL_W-1:0]  rconv_left_vol,
   output logic                   lin2_right_route,
   output logic      [VOL_W-1:0]  lin2_right_vol,
   output logic                   lamp_right_route,
   output logic      [VOL_W-1:0]  lamp_right_vol,
   output logic                   lconv_right_route,
   output logic      [VOL_W-1:0]  lconv_right_vol,
   output logic                   rin2_right_route,
   output logic      [VOL_W-1:0]  rin2_right_vol,
   output logic                   ramp_right_route,
   output logic      [VOL_W-1:0]  ramp_right_vol,
   output logic      [LVL_W-1:0]  left_level,
   output logic                   left_unmute,
   output logic                   left_power,
   output logic                   left_gain_pending
);
   logic [DATA_W-1:0]  path_reg [NPATH];
   logic [LVL_W-1:0]   level_code;
   logic               mute_off;
   logic               rsvd_bit;
   logic               power_on;
   logic [VOL_W-1:0]   vol_applied [NPATH];
   logic [NPATH-1:0]   vol_busy;
   logic [LVL_W-1:0]   level_applied;
   logic               level_busy;
   logic [STEP_CW-1:0] step_cnt;
   logic               step_en;
   logic [2:0]         wr_idx;
   logic [2:0]         rd_idx;
   logic [DATA_W-1:0]  next_rdata;
   logic               pending;

   assign wr_idx = path_index(reg_addr);
   assign rd_idx = path_index(reg_addr);

   // Shared step divider; all gain changes move at this rate
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         step_cnt <= '0;
      end else if (step_cnt == STEP_CW'(STEP_CYC - 1)) begin
         step_cnt <= '0;
      end else begin
         step_cnt <= STEP_CW'(step_cnt + 1'b1);
      end
   end

   assign step_en = (step_cnt == STEP_CW'(STEP_CYC - 1));

   // Path registers: route bit and volume code in one byte
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < NPATH; i++) begin
            path_reg[i] <= PATH_RST;
         end
      end else if (reg_write && (wr_idx < 3'(NPATH))) begin
         path_reg[wr_idx] <= reg_wdata;
      end
   end

   // Level register; the status bit is not writable
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         level_code <= LEVEL_RST[LVL_MSB:LVL_LSB];
         mute_off   <= LEVEL_RST[MUTE_BIT];
         rsvd_bit   <= LEVEL_RST[RSVD_BIT];
         power_on   <= LEVEL_RST[PWR_BIT];
      end else if (reg_write && (reg_addr == OFF_LEFT_LEVEL)) begin
         // Reserved codes are stored as written; the host keeps clear of them
         level_code <= reg_wdata[LVL_MSB:LVL_LSB];
         mute_off   <= reg_wdata[MUTE_BIT];
         rsvd_bit   <= reg_wdata[RSVD_BIT];
         power_on   <= reg_wdata[PWR_BIT];
      end
   end

   // One stepper per path walks the applied volume to the code
   for (genvar g = 0; g < NPATH; g++) begin : g_path
      lom_gain_step #(.W(VOL_W)) u_step (
         .clock   (clock),
         .rst     (rst),
         .step_en (step_en),
         .target  (path_reg[g][VOL_MSB:0]),
         .applied (vol_applied[g]),
         .busy    (vol_busy[g])
      );
   end

   lom_gain_step #(.W(LVL_W)) u_level_step (
      .clock   (clock),
      .rst     (rst),
      .step_en (step_en),
      .target  (level_code),
      .applied (level_applied),
      .busy    (level_busy)
   );

   // Only the two left-output paths and the left level count here
   assign pending = vol_busy[0] | vol_busy[1] | level_busy;

   // Read mux; unmapped addresses read as zero
   always_comb begin
      next_rdata = RD_UNMAPPED;
      if (rd_idx < 3'(NPATH)) begin
         next_rdata = path_reg[rd_idx];
      end else if (reg_addr == OFF_LEFT_LEVEL) begin
         next_rdata[LVL_MSB:LVL_LSB] = level_code;
         next_rdata[MUTE_BIT]        = mute_off;
         next_rdata[RSVD_BIT]        = rsvd_bit;
         next_rdata[PEND_BIT]        = pending;
         next_rdata[PWR_BIT]         = power_on;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rdata <= RD_UNMAPPED;
      end else if (reg_read) begin
         reg_rdata <= next_rdata;
      end
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         reg_rvalid <= 1'b0;
      end else begin
         reg_rvalid <= reg_read;
      end
   end

   // Analog controls: route straight from the bits, gains after stepping
   assign ramp_left_route   = path_reg[0][ROUTE_BIT];
   assign ramp_left_vol     = vol_applied[0];
   assign rconv_left_route  = path_reg[1][ROUTE_BIT];
   assign rconv_left_vol    = vol_applied[1];
   assign lin2_right_route  = path_reg[2][ROUTE_BIT];
   assign lin2_right_vol    = vol_applied[2];
   assign lamp_right_route  = path_reg[3][ROUTE_BIT];
   assign lamp_right_vol    = vol_applied[3];
   assign lconv_right_route = path_reg[4][ROUTE_BIT];
   assign lconv_right_vol   = vol_applied[4];
   assign rin2_right_route  = path_reg[5][ROUTE_BIT];
   assign rin2_right_vol    = vol_applied[5];
   assign ramp_right_route  = path_reg[6][ROUTE_BIT];
   assign ramp_right_vol    = vol_applied[6];

   // Level clipped at 9 dB so a stray reserved code cannot overdrive
   assign left_level        = (level_applied > LVL_MAX) ? LVL_MAX : level_applied;
   assign left_unmute       = mute_off;
   assign left_power        = power_on;
   assign left_gain_pending = pending;
endmodule : lom_regs

/* File: inc/lom_pkg.sv */
// Constants for the line output mixer control registers.
// Assumes a byte-wide register port driven by the control bus front end.
// What this block does
// - Reg 84 D7 routes right amp left
// - Path regs hold 7-bit volume, reset zero
// - Reg 85 D7 routes right converter left
// - Reg 86 D7-D4 left level, 1 dB steps
// - Reg 86 D3 clear mutes left output
// - Reg 86 D1 reads pending left-output gain changes
// - Reg 86 D0 powers left output driver
// - Reg 87 D7 routes second left input right
// - Reg 88 D7 routes left amp right
// - Reg 89 D7 routes left converter right
// - Reg 90 D7 routes second right input right
// - Reg 91 D7 routes right amp right
package lom_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   localparam int VOL_W  = 7;
   localparam int LVL_W  = 4;
   localparam int NPATH  = 7;

   localparam logic [ADDR_W-1:0] OFF_RAMP_LEFT  = 7'h54;
   localparam logic [ADDR_W-1:0] OFF_RCONV_LEFT = 7'h55;
   localparam logic [ADDR_W-1:0] OFF_LEFT_LEVEL = 7'h56;
   localparam logic [ADDR_W-1:0] OFF_LIN2_RIGHT = 7'h57;
   localparam logic [ADDR_W-1:0] OFF_LAMP_RIGHT = 7'h58;
   localparam logic [ADDR_W-1:0] OFF_LCONV_RIGHT = 7'h59;
   localparam logic [ADDR_W-1:0] OFF_RIN2_RIGHT = 7'h5a;
   localparam logic [ADDR_W-1:0] OFF_RAMP_RIGHT = 7'h5b;

   localparam logic [ADDR_W-1:0] PATH_OFF [NPATH] = '{
      OFF_RAMP_LEFT, OFF_RCONV_LEFT, OFF_LIN2_RIGHT, OFF_LAMP_RIGHT,
      OFF_LCONV_RIGHT, OFF_RIN2_RIGHT, OFF_RAMP_RIGHT};

   localparam int ROUTE_BIT = 7;
   localparam int VOL_MSB   = 6;
   localparam int LVL_MSB   = 7;
   localparam int LVL_LSB   = 4;
   localparam int MUTE_BIT  = 3;
   localparam int RSVD_BIT  = 2;
   localparam int PEND_BIT  = 1;
   localparam int PWR_BIT   = 0;

   localparam logic [DATA_W-1:0] PATH_RST   = 8'h00;
   localparam logic [DATA_W-1:0] LEVEL_RST  = 8'h00;
   localparam logic [DATA_W-1:0] RD_UNMAPPED = 8'h00;
   localparam logic [LVL_W-1:0]  LVL_MAX    = 4'h9;

   localparam int CLK_NS   = 40;
   localparam int STEP_NS  = 1000;
   localparam int STEP_CYC = (STEP_NS + CLK_NS - 1) / CLK_NS;
   localparam int STEP_CW  = $clog2(STEP_CYC + 1);

   // Index of a mixer path register, or NPATH when no path matches
   function automatic logic [2:0] path_index(input logic [ADDR_W-1:0] a);
      logic [2:0] idx;
      idx = 3'(NPATH);
      for (int i = 0; i < NPATH; i++) begin
         if (a == PATH_OFF[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction : path_index
endpackage : lom_pkg

/* File: verif/lom_host.sv */
// Host model: byte register cycles on the falling edge.
// Assumes the one-cycle strobe port of lom_regs.
module lom_host
   import lom_pkg::*;
(
   input  wire logic              clock,
   input  wire logic [DATA_W-1:0] reg_rdata,
   input  wire logic              reg_rvalid,
   output logic      [ADDR_W-1:0] reg_addr,
   output logic      [DATA_W-1:0] reg_wdata,
   output logic                   reg_write,
   output logic                   reg_read
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_addr = 7'h00;
      reg_wdata = 8'h00;
      reg_write = 1'b0;
      reg_read = 1'b0;
   end
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] w);
      logic [DATA_W-1:0] x;
      x = w;
      if (a == OFF_LEFT_LEVEL) begin
         x[RSVD_BIT] = 1'b0;
         if (x[LVL_MSB:LVL_LSB] > LVL_MAX) x[LVL_MSB:LVL_LSB] = LVL_MAX;
      end
      @(negedge clock);
      reg_addr = a;
      reg_wdata = x;
      reg_write = 1'b1;
      @(negedge clock);
      reg_write = 1'b0;
      // Released data lines never keep the last value; reg_addr holds it
      reg_wdata = ~x;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(negedge clock);
      reg_addr = a;
      reg_read = 1'b1;
      @(negedge clock);
      reg_read = 1'b0;
      reg_addr = ~a;
      d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hxx;
   endtask : rd
endmodule : lom_host

/* File: verif/lom_regs_assertions.sv */
// Checker for the mixer register ports.
// Bound to lom_regs; one clock domain.
module lom_regs_assertions (
   input wire logic       clock,
   input wire logic       rst,
   input wire logic [6:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic       reg_write,
   input wire logic       reg_read,
   input wire logic       reg_rvalid,
   input wire logic       ramp_left_route,
   input wire logic       rconv_left_route,
   input wire logic       ramp_right_route,
   input wire logic [6:0] ramp_left_vol,
   input wire logic [3:0] left_level,
   input wire logic       left_unmute,
   input wire logic       left_power
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   a_read_valid: assert property (reg_read |=> reg_rvalid) else $error("no rvalid");
   a_route_left_amp: assert property (reg_write && reg_addr == 7'h54 |=>
      ramp_left_route == $past(reg_wdata[7])) else $error("route 54");
   a_route_left_conv: assert property (reg_write && reg_addr == 7'h55 |=>
      rconv_left_route == $past(reg_wdata[7])) else $error("route 55");
   a_route_right_amp: assert property (reg_write && reg_addr == 7'h5b |=>
      ramp_right_route == $past(reg_wdata[7])) else $error("route 5b");
   a_unmute_follows: assert property (reg_write && reg_addr == 7'h56 |=>
      left_unmute == $past(reg_wdata[3])) else $error("mute bit");
   a_power_follows: assert property (reg_write && reg_addr == 7'h56 |=>
      left_power == $past(reg_wdata[0])) else $error("power bit");
   a_level_clipped: assert property (left_level <= 4'h9) else $error("level");
   a_vol_steps: assert property ($changed(ramp_left_vol) |->
      7'(ramp_left_vol - $past(ramp_left_vol)) inside {7'h01, 7'h7f}) else $error("step");
endmodule : lom_regs_assertions

bind lom_regs lom_regs_assertions i_lom_regs_assertions (.clock(clock), .rst(rst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
   .reg_read(reg_read), .reg_rvalid(reg_rvalid), .ramp_left_route(ramp_left_route),
   .rconv_left_route(rconv_left_route), .ramp_right_route(ramp_right_route),
   .ramp_left_vol(ramp_left_vol), .left_level(left_level),
   .left_unmute(left_unmute), .left_power(left_power));

/* File: verif/test_lom_regs.sv */
// Bench for the mixer registers: random and corner path and level codes.
// Uses lom_host for bus cycles and the bound checker.
module test_lom_regs
   import lom_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic             clock = 1'b0;
   logic             rst = 1'b1;
   logic [6:0]       reg_addr;
   logic [7:0]       reg_wdata, reg_rdata, d, v;
   logic             reg_write, reg_read, reg_rvalid, pend, unm, pwr;
   logic             route [NPATH];
   logic [6:0]       vol [NPATH];
   logic [3:0]       lvl, lv;
   int               bad_count = 0, checks = 0, i, r, n;
   always #20 clock = ~clock;
   lom_host i_lom_host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read));
   lom_regs i_lom_regs (.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
      .reg_rvalid(reg_rvalid), .ramp_left_route(route[0]), .ramp_left_vol(vol[0]),
      .rconv_left_route(route[1]), .rconv_left_vol(vol[1]), .lin2_right_route(route[2]),
      .lin2_right_vol(vol[2]), .lamp_right_route(route[3]), .lamp_right_vol(vol[3]),
      .lconv_right_route(route[4]), .lconv_right_vol(vol[4]), .rin2_right_route(route[5]),
      .rin2_right_vol(vol[5]), .ramp_right_route(route[6]), .ramp_right_vol(vol[6]),
      .left_level(lvl), .left_unmute(unm), .left_power(pwr), .left_gain_pending(pend));
   task wrap_up;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : wrap_up
   task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
      checks++;
      if (s !== e) begin
         $display("wrong value %s expected %h seen %h", nm, e, s);
         bad_count++;
      end
   endtask : chk
   function automatic logic [7:0] cur(input int k);
      return (k < NPATH) ? {1'b0, vol[k]} : {4'h0, lvl};
   endfunction : cur
   // Bound covers a full 127-step ramp at 25 cycles a step
   task settle(input int k, input logic [7:0] e);
      for (n = 0; n < 4000 && cur(k) !== e; n++) @(negedge clock);
      chk("settled gain", e, cur(k));
      if (n == 4000) wrap_up;
   endtask : settle
   function automatic logic [7:0] lvl_byte(input logic [3:0] l, input logic m, input logic p);
      return {l, m, 1'b0, 1'b0, p};
   endfunction : lvl_byte
   initial begin
      n = $urandom(39);
      repeat (5) @(negedge clock);
      rst = 1'b0;
      for (i = 0; i < 8; i++) begin
         i_lom_host.rd(7'h54 + 7'(i), d);
         chk("reset value", 8'h00, d);
      end
      i_lom_host.rd(7'h33, d);
      chk("unmapped read", RD_UNMAPPED, d);
      // Neighbour just below the map must not alias onto the first path
      i_lom_host.wr(7'h53, 8'hff);
      i_lom_host.rd(OFF_RAMP_LEFT, d);
      chk("unmapped write", 8'h00, d);
      for (r = 0; r < 3; r++) begin
         for (i = 0; i < NPATH; i++) begin
            v = (r == 0) ? 8'($urandom) : ((r == 1) ? 8'hff : 8'h00);
            i_lom_host.wr(PATH_OFF[i], v);
            chk("route", {7'h00, v[7]}, {7'h00, route[i]});
            if (r == 2 && i < 2) chk("pending", 8'h01, {7'h00, pend});
            settle(i, {1'b0, v[6:0]});
            i_lom_host.rd(PATH_OFF[i], d);
            chk("path readback", v, d);
         end
      end
      for (r = 0; r < 4; r++) begin
         lv = (r == 0) ? 4'h9 : ((r == 1) ? 4'h0 : 4'($urandom_range(9)));
         v = lvl_byte(lv, 1'($urandom), 1'($urandom));
         i_lom_host.wr(OFF_LEFT_LEVEL, v);
         chk("unmute", {7'h00, v[3]}, {7'h00, unm});
         chk("power", {7'h00, v[0]}, {7'h00, pwr});
         if (r < 2) chk("pending", 8'h01, {7'h00, pend});
         // A nine-step walk outlasts the read, so D1 must still read one
         if (r < 2) i_lom_host.rd(OFF_LEFT_LEVEL, d);
         if (r < 2) chk("pending readback", v | 8'h02, d);
         settle(NPATH, {4'h0, lv});
         chk("pending", 8'h00, {7'h00, pend});
         i_lom_host.rd(OFF_LEFT_LEVEL, d);
         chk("level readback", v, d);
      end
      wrap_up;
   end
endmodule : test_lom_regs
